// File: lesq_pkg.sv
// Package with register map, field layout, timing constants and types of the sequencer
package lesq_pkg;
	localparam int unsigned LESQ_DATA_W        = 32;
	localparam int unsigned LESQ_ADDR_W        = 8;
	localparam int unsigned LESQ_DEPTH         = 16;
	localparam int unsigned LESQ_IDX_W         = 4;
	localparam int unsigned LESQ_CHANNELS      = 4;
	// One tick is one clock cycle of LESQ_CLK_PERIOD_NS; the LESQ_TICK_NS figure differs from it and is unused
	localparam int unsigned LESQ_TICK_NS       = 15;
	localparam int unsigned LESQ_CLK_PERIOD_NS = 50;
	localparam int unsigned LESQ_STROBE_MIN_NS     = 1000;
	localparam int unsigned LESQ_STROBE_LONGEST_NS = 1000000000;
	localparam int unsigned LESQ_STROBE_MAX_ON_NS  = 100000000;
	localparam int unsigned LESQ_STROBE_MIN_CYC    = (LESQ_STROBE_MIN_NS + LESQ_CLK_PERIOD_NS - 1) / LESQ_CLK_PERIOD_NS;
	localparam int unsigned LESQ_STROBE_LONGEST_CYC = LESQ_STROBE_LONGEST_NS / LESQ_CLK_PERIOD_NS;
	localparam int unsigned LESQ_STROBE_MAX_ON_CYC  = LESQ_STROBE_MAX_ON_NS / LESQ_CLK_PERIOD_NS;

	localparam logic [7:0] LESQ_REG_CTRL      = 8'h00;
	localparam logic [7:0] LESQ_REG_STATUS    = 8'h04;
	localparam logic [7:0] LESQ_REG_EXP_DELAY = 8'h08;
	localparam logic [7:0] LESQ_REG_STR_DELAY = 8'h0C;
	localparam logic [7:0] LESQ_REG_STR_DUR   = 8'h10;
	localparam logic [7:0] LESQ_REG_ROUTE     = 8'h14;
	localparam logic [7:0] LESQ_REG_SELECT    = 8'h18;
	localparam logic [7:0] LESQ_REG_LENGTH    = 8'h20;
	localparam logic [7:0] LESQ_REG_A_START   = 8'h24;
	localparam logic [7:0] LESQ_REG_A_STOP    = 8'h28;
	localparam logic [7:0] LESQ_REG_B_START   = 8'h2C;
	localparam logic [7:0] LESQ_REG_B_STOP    = 8'h30;
	localparam logic [7:0] LESQ_REG_PERIOD    = 8'h34;
	localparam logic [7:0] LESQ_REG_ON_TIME0  = 8'h38;
	localparam logic [7:0] LESQ_REG_ON_TIME3  = 8'h44;

	localparam int unsigned LESQ_CTRL_EN_BIT     = 0;
	localparam int unsigned LESQ_CTRL_POL_BIT    = 1;
	localparam int unsigned LESQ_CTRL_LAST_LSB   = 4;
	localparam int unsigned LESQ_CTRL_SWTRIG_BIT = 8;
	localparam int unsigned LESQ_CTRL_NVM_BIT    = 9;
	localparam int unsigned LESQ_STAT_RUN_BIT    = 0;
	localparam int unsigned LESQ_STAT_IDX_LSB    = 4;

	localparam logic [1:0] LESQ_RESP_OKAY   = 2'h0;
	localparam logic [1:0] LESQ_RESP_SLVERR = 2'h2;

	typedef enum logic [0:0] {
		LESQ_IDLE = 1'b0,
		LESQ_RUN  = 1'b1
	} lesq_state_t;

	typedef struct packed {
		logic                          enable;
		logic                          strobe_neg;
		logic [LESQ_IDX_W-1:0]         last_idx;
	} lesq_ctrl_t;

	typedef struct packed {
		logic [LESQ_DATA_W-1:0]                    length;
		logic [LESQ_DATA_W-1:0]                    a_start;
		logic [LESQ_DATA_W-1:0]                    a_stop;
		logic [LESQ_DATA_W-1:0]                    b_start;
		logic [LESQ_DATA_W-1:0]                    b_stop;
		logic [LESQ_DATA_W-1:0]                    period;
		logic [LESQ_CHANNELS-1:0][LESQ_DATA_W-1:0] channel_on_time;
	} lesq_interval_t;
endpackage

// File: lesq_pulse_window.sv
// Window comparator giving one timed pulse within an interval
`timescale 1ns/10ps
module lesq_pulse_window #(
	parameter int unsigned CNT_W = 32
) (
	input  wire logic [CNT_W-1:0] count,
	input  wire logic [CNT_W-1:0] start_at,
	input  wire logic [CNT_W-1:0] stop_at,
	output logic                  active
);
	// High from start tick up to, not including, stop tick
	assign active = (count >= start_at) && (count < stop_at);
endmodule

// File: lesq_pwm_channel.sv
// One PWM channel with period counter restarted at each interval start
`timescale 1ns/10ps
module lesq_pwm_channel #(
	parameter int unsigned CNT_W = 32
) (
	input  wire logic             aclk,
	input  wire logic             aresetn,
	input  wire logic             restart,
	input  wire logic             run,
	input  wire logic [CNT_W-1:0] period,
	input  wire logic [CNT_W-1:0] channel_on_time,
	output logic                  active
);
	logic [CNT_W-1:0] count;
	logic [CNT_W-1:0] next_count;

	assign next_count = count + {{(CNT_W-1){1'b0}}, 1'b1};

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			count <= '0;
		end else if (restart || !run) begin
			count <= '0;
		end else if (next_count >= period) begin
			count <= '0;
		end else begin
			count <= next_count;
		end
	end

	// Full level during on-time, duty is on-time over period
	assign active = run && (count < channel_on_time);

	chk_pwm_wrap: assert property (@(posedge aclk) disable iff (!aresetn)
		run && !restart && (next_count >= period) |=> count == '0)
		else $error("pwm counter did not wrap at period");
	chk_pwm_full_on: assert property (@(posedge aclk) disable iff (!aresetn)
		run && (channel_on_time >= period) && (period != '0) |-> active)
		else $error("pwm not fully on for on-time at period");
endmodule

// File: lesq_sequencer.sv
// Trigger-started exposure and light sequencer with AXI4-Lite registers
// Behaviour
// - All times are counted in ticks, one tick per clock cycle.
// - Up to sixteen intervals, each with its own timing and PWM settings.
// - A trigger starts the intervals in order, beginning with the first.
// - Each interval lasts its programmed tick count, then the next begins.
// - Exposure pulse runs from its start to stop tick within the interval.
// - Strobe pulse runs from its start to stop tick within the interval.
// - Each interval's PWM period sets the modulation period of all channels.
// - PWM outputs switch fully high during on-time; duty sets intensity.
// - Exposure start waits a programmable delay after the trigger rising edge.
// - Strobe output polarity is selectable, positive or negative.
// - Strobe duration is programmable, clamped between one microsecond and one second.
// - Strobe output waits a programmable delay after the trigger rising edge.
// - Continuous strobe on-time never exceeds 100 milliseconds.
// - Four PWM channels, each with its own on-time per interval.
// - Settings can be handed to nonvolatile memory by a store request.
// - First pulse gates exposure, second pulse gates strobe.
// - Each PWM channel can be connected to its output line.
// - On-time is held per interval; duty equals on-time over period.
//
// Decided for this implementation: the AXI4-Lite register port and the register offsets.
`timescale 1ns/10ps
module lesq_sequencer #(
	parameter int unsigned STROBE_MAX_ON_CYC  = lesq_pkg::LESQ_STROBE_MAX_ON_CYC,
	parameter int unsigned STROBE_LONGEST_CYC = lesq_pkg::LESQ_STROBE_LONGEST_CYC
) (
	input  wire logic                                  aclk,
	input  wire logic                                  aresetn,
	input  wire logic [lesq_pkg::LESQ_ADDR_W-1:0]      awaddr,
	input  wire logic                                  awvalid,
	output logic                                       awready,
	input  wire logic [lesq_pkg::LESQ_DATA_W-1:0]      wdata,
	input  wire logic [lesq_pkg::LESQ_DATA_W/8-1:0]    wstrb,
	input  wire logic                                  wvalid,
	output logic                                       wready,
	output logic [1:0]                                 bresp,
	output logic                                       bvalid,
	input  wire logic                                  bready,
	input  wire logic [lesq_pkg::LESQ_ADDR_W-1:0]      araddr,
	input  wire logic                                  arvalid,
	output logic                                       arready,
	output logic [lesq_pkg::LESQ_DATA_W-1:0]           rdata,
	output logic [1:0]                                 rresp,
	output logic                                       rvalid,
	input  wire logic                                  rready,
	input  wire logic                                  trigger_in,
	output logic                                       exposure_out,
	output logic                                       strobe_out,
	output logic [lesq_pkg::LESQ_CHANNELS-1:0]         led_out,
	output logic                                       nvm_store_req
);
	import lesq_pkg::*;

	localparam logic [LESQ_DATA_W-1:0] ONE = {{(LESQ_DATA_W-1){1'b0}}, 1'b1};

	lesq_interval_t                intervals [LESQ_DEPTH];
	lesq_ctrl_t                    ctrl;
	lesq_state_t                   state;
	logic [LESQ_DATA_W-1:0]        exp_delay;
	logic [LESQ_DATA_W-1:0]        str_delay;
	logic [LESQ_DATA_W-1:0]        str_dur;
	logic [LESQ_CHANNELS-1:0]      route;
	logic [LESQ_IDX_W-1:0]         sel;
	logic                          sw_trig;
	logic [LESQ_ADDR_W-1:0]        wr_addr;
	logic [LESQ_DATA_W-1:0]        wr_data;
	logic [LESQ_DATA_W/8-1:0]      wr_strb;
	logic                          do_write;
	logic [LESQ_DATA_W-1:0]        next_rdata;
	logic [1:0]                    next_rresp;
	logic                          wr_mapped;
	logic                          trig_prev;
	logic                          seq_start;
	logic                          advance;
	logic                          interval_start;
	logic [LESQ_IDX_W-1:0]         idx;
	logic [LESQ_DATA_W-1:0]        icnt;
	logic [LESQ_DATA_W-1:0]        since;
	logic [LESQ_DATA_W-1:0]        str_on_cnt;
	logic [LESQ_DATA_W-1:0]        str_limit;
	logic                          running;
	logic                          win_a;
	logic                          win_b;
	logic                          str_raw;
	logic [LESQ_CHANNELS-1:0]      pwm_act;
	lesq_interval_t                cur;

	function automatic logic [LESQ_DATA_W-1:0] merge(input logic [LESQ_DATA_W-1:0] old_v,
		input logic [LESQ_DATA_W-1:0] new_v, input logic [LESQ_DATA_W/8-1:0] strb);
		logic [LESQ_DATA_W-1:0] res;
		res = old_v;
		for (int b = 0; b < LESQ_DATA_W/8; b++) begin
			if (strb[b]) begin
				res[b*8 +: 8] = new_v[b*8 +: 8];
			end
		end
		return res;
	endfunction

	// Write address and data capture, either order
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			awready <= 1'b1;
			wr_addr <= '0;
		end else if (awvalid && awready) begin
			awready <= 1'b0;
			wr_addr <= awaddr;
		end else if (bvalid && bready) begin
			awready <= 1'b1;
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			wready  <= 1'b1;
			wr_data <= '0;
			wr_strb <= '0;
		end else if (wvalid && wready) begin
			wready  <= 1'b0;
			wr_data <= wdata;
			wr_strb <= wstrb;
		end else if (bvalid && bready) begin
			wready <= 1'b1;
		end
	end

	assign do_write  = !awready && !wready && !bvalid;
	assign wr_mapped = (wr_addr <= LESQ_REG_SELECT && wr_addr != LESQ_REG_STATUS)
		|| (wr_addr >= LESQ_REG_LENGTH && wr_addr <= LESQ_REG_ON_TIME3);

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			bvalid <= 1'b0;
			bresp  <= LESQ_RESP_OKAY;
		end else if (do_write) begin
			bvalid <= 1'b1;
			bresp  <= (wr_mapped && wr_addr[1:0] == 2'h0) ? LESQ_RESP_OKAY : LESQ_RESP_SLVERR;
		end else if (bready) begin
			bvalid <= 1'b0;
		end
	end

	// Global settings
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			ctrl      <= '0;
			exp_delay <= '0;
			str_delay <= '0;
			str_dur   <= '0;
			route     <= '0;
			sel       <= '0;
		end else if (do_write) begin
			case (wr_addr)
				LESQ_REG_CTRL: begin
					ctrl.enable     <= wr_strb[0] ? wr_data[LESQ_CTRL_EN_BIT] : ctrl.enable;
					ctrl.strobe_neg <= wr_strb[0] ? wr_data[LESQ_CTRL_POL_BIT] : ctrl.strobe_neg;
					ctrl.last_idx   <= wr_strb[0] ? wr_data[LESQ_CTRL_LAST_LSB +: LESQ_IDX_W] : ctrl.last_idx;
				end
				LESQ_REG_EXP_DELAY: exp_delay <= merge(exp_delay, wr_data, wr_strb);
				LESQ_REG_STR_DELAY: str_delay <= merge(str_delay, wr_data, wr_strb);
				LESQ_REG_STR_DUR:   str_dur <= merge(str_dur, wr_data, wr_strb);
				LESQ_REG_ROUTE:     route <= wr_strb[0] ? wr_data[LESQ_CHANNELS-1:0] : route;
				LESQ_REG_SELECT:    sel <= wr_strb[0] ? wr_data[LESQ_IDX_W-1:0] : sel;
				default: begin
				end
			endcase
		end
	end

	// Self-clearing command strobes
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			sw_trig       <= 1'b0;
			nvm_store_req <= 1'b0;
		end else begin
			sw_trig       <= do_write && wr_addr == LESQ_REG_CTRL && wr_strb[1] && wr_data[LESQ_CTRL_SWTRIG_BIT];
			nvm_store_req <= do_write && wr_addr == LESQ_REG_CTRL && wr_strb[1] && wr_data[LESQ_CTRL_NVM_BIT];
		end
	end

	// Per-interval table, reached through the select register
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			for (int i = 0; i < LESQ_DEPTH; i++) begin
				intervals[i] <= '0;
			end
		end else if (do_write) begin
			case (wr_addr)
				LESQ_REG_LENGTH:  intervals[sel].length <= merge(intervals[sel].length, wr_data, wr_strb);
				LESQ_REG_A_START: intervals[sel].a_start <= merge(intervals[sel].a_start, wr_data, wr_strb);
				LESQ_REG_A_STOP:  intervals[sel].a_stop <= merge(intervals[sel].a_stop, wr_data, wr_strb);
				LESQ_REG_B_START: intervals[sel].b_start <= merge(intervals[sel].b_start, wr_data, wr_strb);
				LESQ_REG_B_STOP:  intervals[sel].b_stop <= merge(intervals[sel].b_stop, wr_data, wr_strb);
				LESQ_REG_PERIOD:  intervals[sel].period <= merge(intervals[sel].period, wr_data, wr_strb);
				default: begin
					for (int c = 0; c < LESQ_CHANNELS; c++) begin
						if (wr_addr == LESQ_REG_ON_TIME0 + 8'(4 * c)) begin
							intervals[sel].channel_on_time[c] <= merge(intervals[sel].channel_on_time[c],
								wr_data, wr_strb);
						end
					end
				end
			endcase
		end
	end

	// Read decode
	always_comb begin
		next_rdata = '0;
		next_rresp = LESQ_RESP_OKAY;
		case (araddr)
			LESQ_REG_CTRL: begin
				next_rdata[LESQ_CTRL_EN_BIT]                   = ctrl.enable;
				next_rdata[LESQ_CTRL_POL_BIT]                  = ctrl.strobe_neg;
				next_rdata[LESQ_CTRL_LAST_LSB +: LESQ_IDX_W]   = ctrl.last_idx;
			end
			LESQ_REG_STATUS: begin
				next_rdata[LESQ_STAT_RUN_BIT]                  = running;
				next_rdata[LESQ_STAT_IDX_LSB +: LESQ_IDX_W]    = idx;
			end
			LESQ_REG_EXP_DELAY: next_rdata = exp_delay;
			LESQ_REG_STR_DELAY: next_rdata = str_delay;
			LESQ_REG_STR_DUR:   next_rdata = str_dur;
			LESQ_REG_ROUTE:     next_rdata[LESQ_CHANNELS-1:0] = route;
			LESQ_REG_SELECT:    next_rdata[LESQ_IDX_W-1:0] = sel;
			LESQ_REG_LENGTH:    next_rdata = intervals[sel].length;
			LESQ_REG_A_START:   next_rdata = intervals[sel].a_start;
			LESQ_REG_A_STOP:    next_rdata = intervals[sel].a_stop;
			LESQ_REG_B_START:   next_rdata = intervals[sel].b_start;
			LESQ_REG_B_STOP:    next_rdata = intervals[sel].b_stop;
			LESQ_REG_PERIOD:    next_rdata = intervals[sel].period;
			default: begin
				next_rresp = LESQ_RESP_SLVERR;
				for (int c = 0; c < LESQ_CHANNELS; c++) begin
					if (araddr == LESQ_REG_ON_TIME0 + 8'(4 * c)) begin
						next_rdata = intervals[sel].channel_on_time[c];
						next_rresp = LESQ_RESP_OKAY;
					end
				end
			end
		endcase
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			arready <= 1'b1;
			rvalid  <= 1'b0;
			rdata   <= '0;
			rresp   <= LESQ_RESP_OKAY;
		end else if (arvalid && arready) begin
			arready <= 1'b0;
			rvalid  <= 1'b1;
			rdata   <= next_rdata;
			rresp   <= next_rresp;
		end else if (rvalid && rready) begin
			arready <= 1'b1;
			rvalid  <= 1'b0;
		end
	end

	// Trigger edge and interval stepping
	assign running        = (state == LESQ_RUN);
	assign seq_start      = ctrl.enable && !running && ((trigger_in && !trig_prev) || sw_trig);
	assign advance        = running && (icnt + ONE >= cur.length) && (idx != ctrl.last_idx);
	assign interval_start = seq_start || advance;
	assign cur            = intervals[idx];

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			trig_prev <= 1'b0;
		end else begin
			trig_prev <= trigger_in;
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			state <= LESQ_IDLE;
			idx   <= '0;
			icnt  <= '0;
		end else begin
			case (state)
				LESQ_IDLE: begin
					if (seq_start) begin
						state <= LESQ_RUN;
						idx   <= '0;
						icnt  <= '0;
					end
				end
				LESQ_RUN: begin
					if (icnt + ONE >= cur.length) begin
						icnt <= '0;
						if (idx == ctrl.last_idx) begin
							state <= LESQ_IDLE;
						end else begin
							idx <= idx + 4'h1;
						end
					end else begin
						icnt <= icnt + ONE;
					end
				end
				default: state <= LESQ_IDLE;
			endcase
		end
	end

	// Ticks since trigger, saturating
	always_ff @(posedge aclk) begin
		if (!aresetn || seq_start) begin
			since <= '0;
		end else if (running && since != '1) begin
			since <= since + ONE;
		end
	end

	lesq_pulse_window #(.CNT_W(LESQ_DATA_W)) u_win_a (
		.count    (icnt),
		.start_at (cur.a_start),
		.stop_at  (cur.a_stop),
		.active   (win_a)
	);

	lesq_pulse_window #(.CNT_W(LESQ_DATA_W)) u_win_b (
		.count    (icnt),
		.start_at (cur.b_start),
		.stop_at  (cur.b_stop),
		.active   (win_b)
	);

	for (genvar c = 0; c < LESQ_CHANNELS; c++) begin : g_pwm
		lesq_pwm_channel #(.CNT_W(LESQ_DATA_W)) u_pwm (
			.aclk            (aclk),
			.aresetn         (aresetn),
			.restart         (interval_start),
			.run             (running),
			.period          (cur.period),
			.channel_on_time (cur.channel_on_time[c]),
			.active          (pwm_act[c])
		);
	end

	// Strobe length: duration clamped, then capped at the maximum on-time
	always_comb begin
		str_limit = str_dur;
		if (str_limit < LESQ_DATA_W'(LESQ_STROBE_MIN_CYC)) begin
			str_limit = LESQ_DATA_W'(LESQ_STROBE_MIN_CYC);
		end
		if (str_limit > LESQ_DATA_W'(STROBE_LONGEST_CYC)) begin
			str_limit = LESQ_DATA_W'(STROBE_LONGEST_CYC);
		end
		if (str_limit > LESQ_DATA_W'(STROBE_MAX_ON_CYC)) begin
			str_limit = LESQ_DATA_W'(STROBE_MAX_ON_CYC);
		end
	end

	assign str_raw = running && win_b && (since >= str_delay);

	always_ff @(posedge aclk) begin
		if (!aresetn || !str_raw) begin
			str_on_cnt <= '0;
		end else if (str_on_cnt < str_limit) begin
			str_on_cnt <= str_on_cnt + ONE;
		end
	end

	// Registered outputs
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			exposure_out <= 1'b0;
			strobe_out   <= 1'b0;
			led_out      <= '0;
		end else begin
			exposure_out <= running && win_a && (since >= exp_delay);
			strobe_out   <= (str_raw && (str_on_cnt < str_limit)) ^ ctrl.strobe_neg;
			led_out      <= running ? (pwm_act & route) : '0;
		end
	end

	chk_start_first: assert property (@(posedge aclk) disable iff (!aresetn)
		seq_start |=> running && idx == '0 && icnt == '0)
		else $error("sequence did not start at first interval");
	chk_interval_step: assert property (@(posedge aclk) disable iff (!aresetn)
		advance |=> icnt == '0 && idx == $past(idx) + 4'h1)
		else $error("interval did not advance at its length");
	chk_last_stop: assert property (@(posedge aclk) disable iff (!aresetn)
		!running && $past(!running) |=> !exposure_out && led_out == '0
			&& strobe_out == $past(ctrl.strobe_neg))
		else $error("outputs active while idle");
	chk_exp_window: assert property (@(posedge aclk) disable iff (!aresetn)
		running && (icnt < cur.a_start || icnt >= cur.a_stop) |=> !exposure_out)
		else $error("exposure outside its window");
	chk_exp_delay: assert property (@(posedge aclk) disable iff (!aresetn)
		running && since < exp_delay |=> !exposure_out)
		else $error("exposure before its delay");
	chk_strobe_delay: assert property (@(posedge aclk) disable iff (!aresetn)
		running && since < str_delay |=> strobe_out == $past(ctrl.strobe_neg))
		else $error("strobe before its delay");
	chk_strobe_cap: assert property (@(posedge aclk) disable iff (!aresetn)
		str_on_cnt == LESQ_DATA_W'(STROBE_MAX_ON_CYC) |=> strobe_out == $past(ctrl.strobe_neg))
		else $error("strobe still on at its cap");
	chk_strobe_min: assert property (@(posedge aclk) disable iff (!aresetn)
		$rose(str_raw) ##1 str_raw [*8] |-> (strobe_out != ctrl.strobe_neg) [*8])
		else $error("strobe shorter than least duration");
	chk_led_route: assert property (@(posedge aclk) disable iff (!aresetn)
		running |=> (led_out & ~$past(route)) == '0)
		else $error("unrouted channel drives its output");
	chk_store_pulse: assert property (@(posedge aclk) disable iff (!aresetn)
		nvm_store_req |=> !nvm_store_req)
		else $error("store request longer than one cycle");
endmodule

// File: lesq_light_model.sv
// Behavioural model of the trigger source, sensor exposure input and LED lights
`timescale 1ns/10ps
module lesq_light_model (
	input  wire logic       aclk,
	input  wire logic       clear,
	input  wire logic       fire,
	input  wire logic       pol,
	input  wire logic       exposure_out,
	input  wire logic       strobe_out,
	input  wire logic [3:0] led_out,
	output logic            trigger_in,
	output int              exp_cnt,
	output int              str_cnt,
	output int              led_cnt [4]
);
	always_ff @(posedge aclk) begin
		trigger_in <= fire;
	end
	always_ff @(posedge aclk) begin
		if (clear) begin
			exp_cnt <= 0;
			str_cnt <= 0;
			led_cnt <= '{0, 0, 0, 0};
		end else begin
			exp_cnt <= exp_cnt + int'(exposure_out);
			str_cnt <= str_cnt + int'(strobe_out != pol);
			for (int i = 0; i < 4; i++) begin
				led_cnt[i] <= led_cnt[i] + int'(led_out[i]);
			end
		end
	end
endmodule

// File: lesq_testbench.sv
// Self-checking bench for the sequencer
`timescale 1ns/10ps
module testbench;
	import lesq_pkg::*;
	logic        aclk, aresetn, awvalid, wvalid, bready, arvalid, rready, clear, fire, pol;
	logic [7:0]  awaddr, araddr;
	logic [31:0] wdata, rdata;
	logic [3:0]  wstrb, led_out;
	logic [1:0]  bresp, rresp;
	logic        awready, wready, bvalid, arready, rvalid, trigger_in, exposure_out, strobe_out, nvm_store_req;
	int          failures, comparisons, exp_cnt, str_cnt, stores;
	int          led_cnt [4];
	logic [33:0] notes [$];
	logic [1:0]  wnotes [$];
	logic [31:0] r;
	lesq_sequencer #(.STROBE_MAX_ON_CYC(40), .STROBE_LONGEST_CYC(100)) dut (.*);
	lesq_light_model model (.*);
	task automatic check(input logic [33:0] seen, input logic [33:0] exp);
		comparisons++;
		if (seen !== exp) begin
			failures++;
			$display("wrong value at %0t: saw %h expected %h", $time, seen, exp);
		end
	endtask
	task automatic final_report;
		if (failures == 0 && comparisons > 0) begin
			$display("Testbench passed");
		end else begin
			$display("Testbench failed");
		end
		$finish;
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] resp);
		bit aw_on, w_on;
		wnotes.push_back(resp);
		awaddr <= a;
		wdata <= d;
		wstrb <= 4'hF;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		aw_on = 1;
		w_on = 1;
		while (aw_on || w_on) begin
			@(posedge aclk);
			if (aw_on && awready) begin
				awvalid <= 1'b0;
				aw_on = 0;
			end
			if (w_on && wready) begin
				wvalid <= 1'b0;
				w_on = 0;
			end
		end
		do @(posedge aclk); while (!bvalid);
	endtask
	task automatic rd(input logic [7:0] a, input logic [33:0] exp);
		notes.push_back(exp);
		araddr <= a;
		arvalid <= 1'b1;
		do @(posedge aclk); while (!arready);
		arvalid <= 1'b0;
		do @(posedge aclk); while (!rvalid);
	endtask
	task automatic iv(input logic [3:0] sel, input int v [10]);
		wr(LESQ_REG_SELECT, 32'(sel), LESQ_RESP_OKAY);
		for (int i = 0; i < 10; i++) begin
			wr(LESQ_REG_LENGTH + 8'(4 * i), 32'(v[i]), LESQ_RESP_OKAY);
		end
	endtask
	task automatic run(input int cycles, input int e, input int s, input int l [4]);
		clear <= 1'b1;
		@(posedge aclk);
		clear <= 1'b0;
		repeat (cycles) @(posedge aclk);
		check(34'(exp_cnt), 34'(e));
		check(34'(str_cnt), 34'(s));
		for (int i = 0; i < 4; i++) begin
			check(34'(led_cnt[i]), 34'(l[i]));
		end
		check(34'({exposure_out, strobe_out, led_out}), 34'({1'b0, pol, 4'h0}));
	endtask
	always @(posedge aclk) begin
		if (rvalid && rready) begin
			check({rresp, rdata}, notes.pop_front());
		end
		if (bvalid && bready) begin
			check(34'(bresp), 34'(wnotes.pop_front()));
		end
		if (nvm_store_req) begin
			stores++;
		end
	end
	initial begin
		aclk = 1'b0;
		forever #25 aclk = ~aclk;
	end
	initial begin
		repeat (20000) @(posedge aclk);
		failures++;
		final_report();
	end
	initial begin
		{aresetn, awvalid, wvalid, arvalid, clear, fire, pol} = '0;
		{bready, rready} = 2'h3;
		{awaddr, araddr, wdata, wstrb} = '0;
		void'($urandom(32'h5AFB6EF5));
		repeat (20) @(posedge aclk);
		aresetn <= 1'b1;
		rd(LESQ_REG_CTRL, 34'h0);
		rd(LESQ_REG_STATUS, 34'h0);
		r = $urandom;
		wr(LESQ_REG_SELECT, 32'hF, LESQ_RESP_OKAY);
		wr(LESQ_REG_LENGTH, r, LESQ_RESP_OKAY);
		rd(LESQ_REG_LENGTH, {2'h0, r});
		wr(LESQ_REG_STATUS, r, LESQ_RESP_SLVERR);
		rd(8'h1C, {LESQ_RESP_SLVERR, 32'h0});
		iv(4'h0, '{20, 2, 6, 3, 8, 4, 4, 1, 3, 2});
		iv(4'h1, '{8, 0, 0, 0, 0, 4, 2, 2, 2, 2});
		wr(LESQ_REG_ROUTE, 32'hB, LESQ_RESP_OKAY);
		wr(LESQ_REG_CTRL, 32'h11, LESQ_RESP_OKAY);
		fork
			run(40, 4, 5, '{24, 9, 0, 14});
			begin
				fire <= 1'b1;
				@(posedge aclk);
				fire <= 1'b0;
				repeat (8) @(posedge aclk);
				fire <= 1'b1;
				@(posedge aclk);
				fire <= 1'b0;
			end
		join
		iv(4'h0, '{60, 2, 6, 0, 60, 4, 4, 1, 3, 2});
		wr(LESQ_REG_EXP_DELAY, 32'h3, LESQ_RESP_OKAY);
		wr(LESQ_REG_STR_DELAY, 32'h2, LESQ_RESP_OKAY);
		wr(LESQ_REG_STR_DUR, 32'h64, LESQ_RESP_OKAY);
		pol <= 1'b1;
		wr(LESQ_REG_CTRL, 32'h303, LESQ_RESP_OKAY);
		run(80, 3, 40, '{60, 15, 0, 30});
		rd(LESQ_REG_CTRL, 34'h3);
		check(34'(stores), 34'h1);
		final_report();
	end
endmodule
